// ---- bench/dbgcs_ctrl_props.sv ----
// Port assertions for the debug control/status byte block
// Assumes it is bound to every dbgcs_ctrl instance
`timescale 1ns/100ps
module dbgcs_ctrl_props
    import dbgcs_pkg::*;
#(
    parameter int STEAL_TIMEOUT = 512
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link and conditions
    input wire dbgcs_req_t link_req,
    input wire logic link_accept,
    input wire logic [7:0] link_rdata,
    input wire logic link_rvalid,
    input wire dbgcs_cond_t cond,
    // Arbitration and status
    input wire logic dbg_access_req,
    input wire logic dbg_access_grant,
    input wire logic debug_enable_bit,
    input wire logic active_debug_mode_flag,
    input wire logic serial_clock_source_bit,
    input wire logic unsecure_status,
    input wire logic erase_pending,
    input wire logic stop_keep_serial_clk,
    input wire logic stop_keep_all_clks,
    input wire logic long_ack_next
);
    localparam int MAX_WAIT = STEAL_TIMEOUT + 2;
    wire logic rd_cmd = link_req.valid && link_req.cmd == DBGCS_CMD_READ;
    wire logic wr_cmd = link_req.valid && link_req.cmd == DBGCS_CMD_WRITE_CS;
    wire logic er_cmd = link_req.valid && link_req.cmd == DBGCS_CMD_ERASE;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_read_answer: assert property (rd_cmd |=> link_rvalid)
        else $error("read not answered");
    chk_secure_refuse: assert property (wr_cmd && cond.secured |-> !link_accept)
        else $error("secured write accepted");
    chk_enable_write: assert property (wr_cmd && !cond.secured && !$past(rst) |=>
        debug_enable_bit == $past(link_req.wdata[7])) else $error("enable not written");
    chk_rdata_image: assert property (link_rvalid |-> !link_rdata[4] &&
        link_rdata[7:6] == $past({debug_enable_bit, active_debug_mode_flag}))
        else $error("read byte wrong");
    chk_ssc_preset: assert property ($past(rst) && cond.special_single_chip |->
        ##[1:2] (debug_enable_bit && active_debug_mode_flag)) else $error("no preset");
    chk_stop_clocks: assert property (stop_keep_serial_clk ==
        (debug_enable_bit && cond.stop_mode) && (!stop_keep_all_clks || stop_keep_serial_clk))
        else $error("stop clock select wrong");
    chk_long_ack: assert property ($rose(cond.stop_mode) && cond.ack_enabled &&
        debug_enable_bit && !link_req.valid ##1 !link_req.valid |-> ##[0:1] long_ack_next)
        else $error("no long acknowledge");
    chk_steal_bound: assert property (dbg_access_req |-> ##[1:MAX_WAIT] dbg_access_grant)
        else $error("access never granted");
    chk_no_handshake: assert property (dbg_access_req && !cond.ack_enabled |=>
        dbg_access_grant) else $error("access not next cycle");
    chk_clksrc_sticky: assert property (serial_clock_source_bit |=>
        serial_clock_source_bit) else $error("clock source cleared");
    chk_unsecure_status_flag: assert property (unsecure_status == !cond.secured)
        else $error("unsecure flag wrong");
    chk_erase_cause: assert property ($rose(erase_pending) |-> $past(er_cmd))
        else $error("erase set without command");
    chk_erase_clear: assert property (cond.erase_done && !er_cmd |=> !erase_pending)
        else $error("erase not cleared");
endmodule : dbgcs_ctrl_props
bind dbgcs_ctrl dbgcs_ctrl_props #(.STEAL_TIMEOUT(STEAL_TIMEOUT)) dbgcs_ctrl_props_i (.*);

// ---- bench/dbgcs_host_model.sv ----
// Behavioural debug host issuing link commands
// Assumes the bench calls send from one process at a time
`timescale 1ns/100ps
module dbgcs_host_model
    import dbgcs_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Link
    output dbgcs_req_t link_req,
    input wire logic [7:0] link_rdata,
    input wire logic link_rvalid
);
    logic [7:0] rd_reg;
    initial link_req = '0;
    task automatic send(input dbgcs_cmd_t cmd, input logic [7:0] wd);
        @(posedge core_clk) #1;
        link_req = '{1'b1, cmd, wd};
        @(posedge core_clk) #1;
        link_req = '{1'b0, DBGCS_CMD_NONE, ~wd};
        rd_reg = link_rvalid ? link_rdata : 8'hxx;
        if (cmd == DBGCS_CMD_WRITE_CS && wd[2]) #1500;
    endtask : send
endmodule : dbgcs_host_model

// ---- bench/tb_dbgcs_ctrl.sv ----
// Self-checking bench for the debug control/status byte block
// Assumes the host model and the bound checker beside it
`timescale 1ns/100ps
module tb_dbgcs_ctrl
    import dbgcs_pkg::*;
;
    localparam int STEAL = 8;
    logic core_clk = 0, rst = 1, dbg_access_req = 0, bus_free = 0, act_e = 0;
    logic link_accept, link_rvalid, grant, ks, ka, la, ae;
    logic [7:0] link_rdata, shadow = '0;
    dbgcs_req_t link_req;
    dbgcs_cond_t cond = '0;
    int n_errors = 0, n_checks = 0, cyc = 0;
    dbgcs_ctrl #(.STEAL_TIMEOUT(STEAL)) dbgcs_ctrl_i (.core_clk(core_clk), .rst(rst),
        .link_req(link_req), .link_accept(link_accept), .link_rdata(link_rdata),
        .link_rvalid(link_rvalid), .cond(cond), .dbg_access_req(dbg_access_req),
        .bus_free(bus_free), .dbg_access_grant(grant), .debug_enable_bit(),
        .active_debug_mode_flag(), .serial_clock_source_bit(), .unsecure_status(),
        .erase_pending(), .stop_keep_serial_clk(ks), .stop_keep_all_clks(ka),
        .long_ack_next(la), .active_entry_allowed(ae));
    dbgcs_host_model dbgcs_host_model_i (.core_clk(core_clk), .link_req(link_req),
        .link_rdata(link_rdata), .link_rvalid(link_rvalid));
    initial forever #5 core_clk = ~core_clk;
    task automatic complete_run;
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic logic [7:0] exp_byte(input logic [7:0] s, input logic a, input logic sec);
        return {s[7], a, s[5], 1'b0, s[3:2], ~sec, s[0]};
    endfunction : exp_byte
    task automatic rd(input string what);
        dbgcs_host_model_i.send(DBGCS_CMD_READ, 8'h00);
        check(what, exp_byte(shadow, act_e, cond.secured), dbgcs_host_model_i.rd_reg);
    endtask : rd
    task automatic wr(input logic [7:0] d);
        dbgcs_host_model_i.send(DBGCS_CMD_WRITE_CS, d);
        if (!cond.secured) begin
            {shadow[7], shadow[3]} = {d[7], d[3]};
            shadow[2] = shadow[2] | d[2];
            if (!cond.stop_mode) shadow[5] = d[5];
        end
    endtask : wr
    task automatic pulse(input int b);
        @(posedge core_clk) #1 cond[b] = 1'b1;
        @(posedge core_clk) #1 cond[b] = 1'b0;
    endtask : pulse
    task automatic acc(input int lo, input int hi, input string what);
        int n;
        @(posedge core_clk) #1 dbg_access_req = 1'b1;
        @(posedge core_clk) #1 dbg_access_req = 1'b0;
        n = 1;
        while (grant !== 1'b1 && n < 600) begin
            @(posedge core_clk) #1;
            n++;
        end
        check(what, 8'h01, {7'h00, n >= lo && n <= hi});
    endtask : acc
    initial begin
        void'($urandom(32'hc4f8));
        cond.special_single_chip = 1'b1;
        repeat (16) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge core_clk);
        {shadow, act_e, cond.special_single_chip} = {8'h80, 1'b1, 1'b0};
        rd("preset");
        pulse(2); act_e = 0; rd("exit active");
        pulse(3); act_e = 1; rd("enter active");
        pulse(2); act_e = 0;
        for (int i = 0; i < 40; i++) begin
            cond[7:5] = {$urandom % 4 == 0, 2'($urandom)};
            wr(8'($urandom));
            rd("random write");
            check("stop", {6'h00, shadow[7] & cond.stop_mode, shadow[7] & cond.stop_mode
                & shadow[5]}, {6'h00, ks, ka});
            check("entry gate", {7'h00, shadow[7]}, {7'h00, ae});
        end
        cond = '0;
        wr(8'h80);
        cond[6:5] = 2'b11;
        repeat (3) @(posedge core_clk);
        #1 check("long ack", 8'h01, {7'h00, la});
        rd("long ack read");
        check("long ack clear", 8'h00, {7'h00, la});
        cond = '0;
        dbgcs_host_model_i.send(DBGCS_CMD_ERASE, 8'h00); shadow[0] = 1; rd("erase");
        wr(8'h01); rd("erase kept");
        pulse(1); shadow[0] = 0; rd("erase done");
        dbgcs_host_model_i.send(DBGCS_CMD_ERASE, 8'h00); pulse(0); rd("soft reset");
        acc(1, 1, "no handshake");
        cond.ack_enabled = 1; wr(8'h08); acc(1, 1, "steal");
        wr(8'h00); acc(STEAL, STEAL + 2, "timeout");
        bus_free = 1; acc(2, 2, "free cycle");
        wr(8'h04); wr(8'h00); rd("clock sticky");
        @(posedge core_clk) #1 rst = 1'b1;
        @(posedge core_clk) #1 rst = 1'b0;
        shadow = '0; rd("clock reset");
        complete_run();
    end
endmodule : tb_dbgcs_ctrl

// ---- hw/dbgcs_consts.svh ----
// Constants for the debug control/status byte block
// Assumes inclusion by the package only; the design module uses its macros through it
`ifndef DBGCS_CONSTS_SVH
`define DBGCS_CONSTS_SVH

// --------------------------------------------------
// Field positions
// --------------------------------------------------
`define DBGCS_BIT_ENABLE 7
`define DBGCS_BIT_ACTIVE 6
`define DBGCS_BIT_CONT_STOP 5
`define DBGCS_BIT_UNUSED 4
`define DBGCS_BIT_STEAL 3
`define DBGCS_BIT_CLKSRC 2
`define DBGCS_BIT_UNSECURE_STATUS 1
`define DBGCS_BIT_ERASE 0

// --------------------------------------------------
// Reset values and timing
// --------------------------------------------------
`define DBGCS_RESET_NORMAL 8'h00
`define DBGCS_STEAL_TIMEOUT 512
`define DBGCS_SERIAL_CLOCK_SOURCE_BIT_SETTLE_CYC 150

`endif

// ---- hw/dbgcs_ctrl.sv ----
// Debug control/status byte with access arbitration and clock select
// Assumes a link decoder delivering one-cycle command pulses on core_clk
`timescale 1ns/100ps
// Function
// - Byte reads only through debug-link commands; no CPU read path exists.
// - Link writes accepted only while the device is not secured.
// - Bits 3, 2 change only by the write-control-status command; bit 7 also by special single chip reset.
// - Stop-continue bit write ignored while in stop mode.
// - Bits 6, 1, 0 read-only; hardware alone updates them.
// - Enable bit gates active debug mode entry; the accepted command set does not depend on it.
// - Special single chip reset sets enable and active-debug-mode flag.
// - Active flag sets on entering, clears on exiting active debug mode.
// - Stop clocks: bit 5 selects serial-only or all; disabled means no effect.
// - With handshake and enable bit on, first acknowledge after stop entry is long.
// - Handshake on: steal 0 waits free cycle, timeout 512; steal 1 next cycle.
// - Handshake off: access takes the next bus cycle always.
// - Clock-source bit resets 0, set by write, cleared only by reset.
// - Unsecure flag follows security state; allows security bit changes.
// - Erase flag set only by the erase command, not by ordinary writes.
// - Erase flag clears on erase completion or soft reset.
module dbgcs_ctrl
    import dbgcs_pkg::*;
#(
    parameter int STEAL_TIMEOUT = `DBGCS_STEAL_TIMEOUT
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Debug link command port
    input wire dbgcs_req_t link_req,
    output logic link_accept,
    output logic [7:0] link_rdata,
    output logic link_rvalid,
    // Device conditions
    input wire dbgcs_cond_t cond,
    // Debug bus access arbitration
    input wire logic dbg_access_req,
    input wire logic bus_free,
    output logic dbg_access_grant,
    // Control outputs
    output logic debug_enable_bit,
    output logic active_debug_mode_flag,
    output logic serial_clock_source_bit,
    output logic unsecure_status,
    output logic erase_pending,
    output logic stop_keep_serial_clk,
    output logic stop_keep_all_clks,
    output logic long_ack_next,
    output logic active_entry_allowed
);

    // --------------------------------------------------
    // State
    // --------------------------------------------------
    logic enable_reg;
    logic active_reg;
    logic cont_stop_reg;
    logic steal_reg;
    logic clksrc_reg;
    logic erase_reg;
    logic ssc_seen_reg;
    logic stop_prev_reg;
    logic long_ack_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic [9:0] wait_cnt_reg;
    dbgcs_acc_state_t acc_state_reg;
    dbgcs_acc_state_t acc_state_next;

    function automatic logic is_cmd(input dbgcs_req_t r, input dbgcs_cmd_t c);
        is_cmd = r.valid && (r.cmd == c);
    endfunction : is_cmd

    // --------------------------------------------------
    // Command decode
    // --------------------------------------------------
    wire logic rd_cmd = is_cmd(link_req, DBGCS_CMD_READ);
    wire logic wr_cmd = is_cmd(link_req, DBGCS_CMD_WRITE_CS) && !cond.secured;
    wire logic erase_cmd = is_cmd(link_req, DBGCS_CMD_ERASE);
    wire logic stop_entry = cond.stop_mode && !stop_prev_reg;
    wire logic ssc_start = !ssc_seen_reg;
    wire logic [7:0] status_byte = {
        enable_reg, active_reg, cont_stop_reg, 1'b0,
        steal_reg, clksrc_reg, !cond.secured, erase_reg
    };

    assign link_accept = rd_cmd || wr_cmd || erase_cmd;
    assign link_rdata = rdata_reg;
    assign link_rvalid = rvalid_reg;

    // --------------------------------------------------
    // Outputs
    // --------------------------------------------------
    assign debug_enable_bit = enable_reg;
    assign active_debug_mode_flag = active_reg;
    assign serial_clock_source_bit = clksrc_reg;
    assign unsecure_status = !cond.secured;
    assign erase_pending = erase_reg;
    assign stop_keep_serial_clk = enable_reg && cond.stop_mode;
    assign stop_keep_all_clks = enable_reg && cond.stop_mode && cont_stop_reg;
    assign long_ack_next = long_ack_reg;
    assign active_entry_allowed = enable_reg;

    // --------------------------------------------------
    // Control/status byte
    // --------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            enable_reg <= 1'b0;
            active_reg <= 1'b0;
            cont_stop_reg <= 1'b0;
            steal_reg <= 1'b0;
            clksrc_reg <= 1'b0;
            ssc_seen_reg <= 1'b0;
        end else begin
            ssc_seen_reg <= 1'b1;
            if (ssc_start && cond.special_single_chip) begin
                enable_reg <= 1'b1;
            end else if (wr_cmd) begin
                enable_reg <= link_req.wdata[`DBGCS_BIT_ENABLE];
            end
            if (ssc_start && cond.special_single_chip) begin
                active_reg <= 1'b1;
            end else if (cond.enter_active && enable_reg) begin
                active_reg <= 1'b1;
            end else if (cond.exit_active) begin
                active_reg <= 1'b0;
            end
            if (wr_cmd && !cond.stop_mode) begin
                cont_stop_reg <= link_req.wdata[`DBGCS_BIT_CONT_STOP];
            end
            if (wr_cmd) begin
                steal_reg <= link_req.wdata[`DBGCS_BIT_STEAL];
            end
            if (wr_cmd && link_req.wdata[`DBGCS_BIT_CLKSRC]) begin
                clksrc_reg <= 1'b1;
            end
        end
    end

    // --------------------------------------------------
    // Erase flag and read data
    // --------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            erase_reg <= 1'b0;
            rdata_reg <= `DBGCS_RESET_NORMAL;
            rvalid_reg <= 1'b0;
        end else begin
            if (erase_cmd) begin
                erase_reg <= 1'b1;
            end else if (cond.erase_done || cond.soft_reset) begin
                erase_reg <= 1'b0;
            end
            rvalid_reg <= rd_cmd;
            if (rd_cmd) begin
                rdata_reg <= status_byte;
            end
        end
    end

    // --------------------------------------------------
    // Long acknowledge after stop entry
    // --------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stop_prev_reg <= 1'b0;
            long_ack_reg <= 1'b0;
        end else begin
            stop_prev_reg <= cond.stop_mode;
            if (stop_entry && cond.ack_enabled && enable_reg) begin
                long_ack_reg <= 1'b1;
            end else if (link_accept) begin
                long_ack_reg <= 1'b0;
            end
        end
    end

    // --------------------------------------------------
    // Bus access arbitration
    // --------------------------------------------------
    wire logic timeout_hit = (wait_cnt_reg == 10'(STEAL_TIMEOUT - 1));
    wire logic wait_mode = cond.ack_enabled && !steal_reg;

    always_comb begin
        acc_state_next = acc_state_reg;
        unique case (acc_state_reg)
            DBGCS_ACC_IDLE: begin
                if (dbg_access_req) begin
                    acc_state_next = wait_mode ? DBGCS_ACC_WAIT : DBGCS_ACC_GRANT;
                end
            end
            DBGCS_ACC_WAIT: begin
                if (bus_free || timeout_hit) begin
                    acc_state_next = DBGCS_ACC_GRANT;
                end
            end
            DBGCS_ACC_GRANT: begin
                acc_state_next = DBGCS_ACC_IDLE;
            end
            default: begin
                acc_state_next = DBGCS_ACC_IDLE;
            end
        endcase
    end

    assign dbg_access_grant = (acc_state_reg == DBGCS_ACC_GRANT);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc_state_reg <= DBGCS_ACC_IDLE;
            wait_cnt_reg <= 10'h000;
        end else begin
            acc_state_reg <= acc_state_next;
            if (acc_state_reg == DBGCS_ACC_WAIT) begin
                wait_cnt_reg <= wait_cnt_reg + 10'h001;
            end else begin
                wait_cnt_reg <= 10'h000;
            end
        end
    end

endmodule : dbgcs_ctrl

// ---- hw/dbgcs_pkg.sv ----
// Types for the debug control/status byte block
// Assumes the constants header sits beside it
package dbgcs_pkg;
    `include "dbgcs_consts.svh"

    // --------------------------------------------------
    // Link command request
    // --------------------------------------------------
    typedef enum logic [1:0] {
        DBGCS_CMD_NONE,
        DBGCS_CMD_READ,
        DBGCS_CMD_WRITE_CS,
        DBGCS_CMD_ERASE
    } dbgcs_cmd_t;

    typedef struct packed {
        logic valid;
        dbgcs_cmd_t cmd;
        logic [7:0] wdata;
    } dbgcs_req_t;

    // --------------------------------------------------
    // Device condition inputs
    // --------------------------------------------------
    typedef struct packed {
        logic secured;
        logic stop_mode;
        logic ack_enabled;
        logic special_single_chip;
        logic enter_active;
        logic exit_active;
        logic erase_done;
        logic soft_reset;
    } dbgcs_cond_t;

    typedef enum logic [1:0] {
        DBGCS_ACC_IDLE,
        DBGCS_ACC_WAIT,
        DBGCS_ACC_GRANT
    } dbgcs_acc_state_t;
endpackage : dbgcs_pkg
